/* inc/pmw_map.svh */
// named constants for the power-mode and wakeup controller
`ifndef PMW_MAP_SVH
`define PMW_MAP_SVH

// resume timer load; the core restarts one cycle after the timer expires
`define PMW_RESUME_CYC 3'h7
// longest allowed resume latency from a sampled wake event, in cycles
`define PMW_WAKE_MAX_CYC 9

// per-pin pull encodings held through standby and shutdown
`define PMW_PULL_FLOAT 2'h0
`define PMW_PULL_UP 2'h1
`define PMW_PULL_DOWN 2'h2

// reset values
`define PMW_IO_ANALOG_RST 1'h1
`define PMW_RST_PULLUP_RST 1'h1
`define PMW_FLASH_PD_RST 1'h0

`endif

/* inc/pmw_pkg.sv */
// types shared by the power-mode and wakeup controller
package pmw_pkg;

  // operating modes, deepest last
  typedef enum logic [2:0] {
    PMW_RUN, PMW_LOW_POWER_RUN, PMW_SLEEP, PMW_LOW_POWER_SLEEP,
    PMW_STOP0, PMW_STOP1, PMW_STANDBY, PMW_SHUTDOWN
  } pmw_mode_t;

  // controller phases
  typedef enum logic [1:0] {
    pmw_st_active, pmw_st_low, pmw_st_resume
  } pmw_state_t;

  // wakeup sources as seen by the controller
  typedef struct packed {
    logic reset_pin;
    logic io_any;
    logic radio;
    logic brownout_reset;
    logic voltage_detector;
    logic calendar;
    logic independent_watchdog;
    logic low_power_timers;
    logic serial_start;
    logic serial_addr;
    logic serial_frame;
    logic two_wire_addr;
    logic [1:0] wakeup_pins;
  } pmw_wake_t;

  // trigger sources of the interconnect
  typedef struct packed {
    logic tim_sync;
    logic tim_adc;
    logic tim_dma;
    logic adc_watchdog;
    logic cal_alarm;
    logic cal_tamper;
    logic gpio;
    logic brk_clk_fail;
    logic brk_hard_fault;
    logic brk_ram_parity;
    logic brk_flash_ecc;
    logic brk_volt_det;
  } pmw_trig_in_t;

  // gated triggers toward their destinations
  typedef struct packed {
    logic tim_sync;
    logic tim_adc;
    logic tim_dma;
    logic adc_wdg_tim;
    logic break_in;
    logic lptim_trig;
    logic gpio_tim;
    logic gpio_adc;
  } pmw_trig_out_t;

  // regulator, clock, memory and peripheral enables
  typedef struct packed {
    logic core_run;
    logic main_regulator;
    logic low_power_regulator;
    logic pll_allowed;
    logic radio_en;
    logic rng_en;
    logic flash_on;
    logic sram_on;
    logic stop_periph_en;
    logic other_periph_en;
    logic ram_bank_a_clk;
    logic ram_bank_b_clk;
    logic wide_timer_en;
    logic hse_on;
    logic hsi_on;
  } pmw_gate_t;

endpackage

/* hdl/pmw_resume_timer.sv */
// down-counter that paces the core restart after a wake event
`timescale 1ns/1ps
module pmw_resume_timer #(
  parameter int W = 3
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [W-1:0] i_load,
  output logic o_done
);

  logic [W-1:0] cnt;
  wire cnt_last = (cnt == {{(W-1){1'b0}}, 1'b1});

  // a new start reloads, so a late event never shortens the wait
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= '0;
      o_done <= 1'b0;
    end else begin
      cnt <= i_start ? i_load : (cnt != '0 ? cnt - 1'b1 : cnt);
      o_done <= cnt_last && !i_start;
    end
  end

endmodule

/* hdl/pmw_ctrl.sv */
// power-mode sequencer, wakeup routing, i/o hold and trigger gating
// Operation
// - sleep modes halt core, peripherals run; any interrupt resumes within 9 cycles
// - low-power run and sleep use low-power regulator; no pll, radio, random source
// - stop modes: flash off, sram kept, only listed peripherals run
// - stop exits on reset pin, any i/o, or listed peripheral events
// - in stop the external fast oscillator follows radio demand automatically
// - in stop the internal 16m oscillator starts on peripheral request
// - serial port wakes from stop on start bit, address or frame
// - two-wire port wakes from stop on address match
// - standby and shutdown wake only from two wakeup pins or calendar
// - pulls per i/o kept floating, up or down in standby and shutdown
// - pull settings are discarded on leaving shutdown
// - i/os sit analog with schmitt trigger off during and after reset
// - reset pin pull-up off while reset source is internal
// - backup domain moves to backup supply when main supply is gone
// - on backup supply alone, interrupts and calendar events do not wake
// - calendar alarm or tamper triggers low-power timers in every mode
// - timer sync, timer-converter, timer-transfer triggers work outside stop, standby and shutdown only
// - advanced timer break from fault sources, everywhere except stop, standby and shutdown
// - converter watchdog triggers advanced timer outside stop, standby and shutdown only
// - any clock source selectable into wide timer; wide timer active outside stop, standby and shutdown
// - gpio triggers timers and converter except in stop, standby and shutdown; low-power timers always
// - flash power-down only with radio unused and code in sram
// - both ram bank clocks gate independently in sleep modes
// - woken 16m oscillator feeds only requesters, stops when unrequested
`timescale 1ns/1ps
`include "pmw_map.svh"
module pmw_ctrl
  import pmw_pkg::*;
#(
  parameter int IO_N = 16,
  parameter int HSI_N = 4,
  parameter int OSC_N = 6,
  parameter int OSC_W = 3
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire pmw_mode_t i_target_mode,
  input wire logic i_sleep_req,
  input wire logic i_lp_run,
  input wire logic i_irq_event,
  input wire pmw_wake_t i_wake,
  input wire logic i_main_supply_ok,
  input wire logic i_internal_reset,
  input wire logic i_io_release,
  input wire logic i_pull_load,
  input wire logic [2*IO_N-1:0] i_pull_cfg,
  input wire logic i_radio_needs_hse,
  input wire logic i_hse_enable,
  input wire logic i_hsi_enable,
  input wire logic [HSI_N-1:0] i_hsi_req,
  input wire logic i_flash_pd_req,
  input wire logic i_flash_pd_clr,
  input wire logic i_radio_in_use,
  input wire logic i_code_in_sram,
  input wire logic i_ram_a_gate,
  input wire logic i_ram_b_gate,
  input wire pmw_trig_in_t i_trig,
  input wire logic [OSC_N-1:0] i_osc_clks,
  input wire logic [OSC_W-1:0] i_osc_sel,
  output pmw_mode_t o_mode,
  output pmw_gate_t o_gate,
  output pmw_trig_out_t o_trig,
  output logic [HSI_N-1:0] o_hsi_feed,
  output logic o_serial_wake_irq,
  output logic o_two_wire_wake_irq,
  output logic [2*IO_N-1:0] o_pull_cfg,
  output logic o_pull_hold,
  output logic o_io_analog,
  output logic o_reset_pullup_en,
  output logic o_on_backup,
  output logic o_flash_pd,
  output logic o_wide_timer_chan
);

  localparam int RT_W = 3;
  localparam int WAKE_MAX = `PMW_WAKE_MAX_CYC;

  // mode class decoders
  function automatic logic is_stop(input pmw_mode_t m);
    is_stop = (m == PMW_STOP0) || (m == PMW_STOP1);
  endfunction

  function automatic logic is_off(input pmw_mode_t m);
    is_off = (m == PMW_STANDBY) || (m == PMW_SHUTDOWN);
  endfunction

  function automatic logic is_lp(input pmw_mode_t m);
    is_lp = (m == PMW_LOW_POWER_RUN) || (m == PMW_LOW_POWER_SLEEP);
  endfunction

  function automatic logic is_sleep(input pmw_mode_t m);
    is_sleep = (m == PMW_SLEEP) || (m == PMW_LOW_POWER_SLEEP);
  endfunction

  // a run-class target on a sleep request means the matching sleep mode
  function automatic pmw_mode_t low_target(input pmw_mode_t t);
    case (t)
      PMW_RUN: low_target = PMW_SLEEP;
      PMW_LOW_POWER_RUN: low_target = PMW_LOW_POWER_SLEEP;
      default: low_target = t;
    endcase
  endfunction

  pmw_state_t state;
  pmw_state_t next_state;
  pmw_mode_t mode;
  pmw_mode_t next_mode;
  logic flash_pd;
  logic next_flash_pd;
  logic tmr_done;
  logic wake_raw;
  pmw_gate_t next_gate;
  pmw_trig_out_t next_trig;

  assign o_mode = mode;
  assign o_flash_pd = flash_pd;

  // peripheral wake requests that stay alive through stop
  wire serial_wake = i_wake.serial_start | i_wake.serial_addr | i_wake.serial_frame;
  wire tw_wake = i_wake.two_wire_addr;
  wire stop_wake = i_wake.reset_pin | i_wake.io_any | i_wake.radio | i_wake.brownout_reset
                 | i_wake.voltage_detector | i_wake.calendar | i_wake.independent_watchdog
                 | i_wake.low_power_timers | serial_wake | tw_wake;
  wire off_wake = (|i_wake.wakeup_pins) | i_wake.calendar;

  // wake decode by the mode in force
  always_comb begin
    wake_raw = 1'b0;
    case (mode)
      PMW_SLEEP, PMW_LOW_POWER_SLEEP: wake_raw = i_irq_event;
      PMW_STOP0, PMW_STOP1: wake_raw = stop_wake;
      PMW_STANDBY, PMW_SHUTDOWN: wake_raw = off_wake;
      default: wake_raw = 1'b0;
    endcase
  end

  // nothing wakes the device while the main supply is absent
  wire wake_qual = wake_raw && i_main_supply_ok && !o_on_backup;
  wire wake_take = (state == pmw_st_low) && wake_qual;
  wire leave_shutdown = wake_take && (mode == PMW_SHUTDOWN);
  wire leave_off = wake_take && is_off(mode);
  wire run_mode_sel = i_lp_run;

  pmw_resume_timer #(
    .W(RT_W)
  ) u_resume (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(wake_take),
    .i_load(`PMW_RESUME_CYC),
    .o_done(tmr_done)
  );

  // phase and mode sequencing; the target is latched with the request
  always_comb begin
    next_state = state;
    next_mode = mode;
    case (state)
      pmw_st_active: begin
        next_mode = run_mode_sel ? PMW_LOW_POWER_RUN : PMW_RUN;
        if (i_sleep_req) begin
          next_state = pmw_st_low;
          next_mode = low_target(i_target_mode);
        end
      end
      pmw_st_low: begin
        if (wake_take) begin
          next_state = pmw_st_resume;
        end
      end
      pmw_st_resume: begin
        if (tmr_done) begin
          next_state = pmw_st_active;
          next_mode = run_mode_sel ? PMW_LOW_POWER_RUN : PMW_RUN;
        end
      end
      default: begin
        next_state = pmw_st_active;
        next_mode = PMW_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= pmw_st_active;
      mode <= PMW_RUN;
    end else begin
      state <= next_state;
      mode <= next_mode;
    end
  end

  // flash power-down is accepted only when nothing can fetch from flash
  wire pd_ok = i_flash_pd_req && !i_radio_in_use && i_code_in_sram;
  assign next_flash_pd = pd_ok ? 1'b1 : (i_flash_pd_clr ? 1'b0 : flash_pd);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flash_pd <= `PMW_FLASH_PD_RST;
    end else begin
      flash_pd <= next_flash_pd;
    end
  end

  // gating follows the mode being entered, so it lands with the request
  wire link_ok = !is_stop(next_mode) && !is_off(next_mode);
  wire lpreg = is_lp(next_mode) || (next_mode == PMW_STOP1);
  wire nm_stop = is_stop(next_mode);
  wire nm_off = is_off(next_mode);
  wire nm_full = (next_mode == PMW_RUN) || (next_mode == PMW_SLEEP);
  assign next_gate.core_run = (next_state == pmw_st_active);
  assign next_gate.main_regulator = !lpreg && !nm_off;
  assign next_gate.low_power_regulator = lpreg;
  assign next_gate.pll_allowed = nm_full;
  assign next_gate.radio_en = nm_full || nm_stop;
  assign next_gate.rng_en = nm_full;
  assign next_gate.flash_on = link_ok && !next_flash_pd;
  assign next_gate.sram_on = !nm_off;
  assign next_gate.stop_periph_en = !nm_off;
  assign next_gate.other_periph_en = link_ok;
  // the bank gates only bite in sleep; run always clocks both banks
  assign next_gate.ram_bank_a_clk = link_ok && !(is_sleep(next_mode) && i_ram_a_gate);
  assign next_gate.ram_bank_b_clk = link_ok && !(is_sleep(next_mode) && i_ram_b_gate);
  assign next_gate.wide_timer_en = link_ok;
  assign next_gate.hse_on = nm_stop ? i_radio_needs_hse : (!nm_off && i_hse_enable);
  assign next_gate.hsi_on = nm_stop ? (|i_hsi_req) : (!nm_off && i_hsi_enable);

  // interconnect gating; only low-power timer paths survive stop
  assign next_trig.tim_sync = link_ok && i_trig.tim_sync;
  assign next_trig.tim_adc = link_ok && i_trig.tim_adc;
  assign next_trig.tim_dma = link_ok && i_trig.tim_dma;
  assign next_trig.adc_wdg_tim = link_ok && i_trig.adc_watchdog;
  assign next_trig.break_in = link_ok && (i_trig.brk_clk_fail | i_trig.brk_hard_fault
                            | i_trig.brk_ram_parity | i_trig.brk_flash_ecc | i_trig.brk_volt_det);
  assign next_trig.lptim_trig = i_trig.cal_alarm | i_trig.cal_tamper | i_trig.gpio;
  assign next_trig.gpio_tim = link_ok && i_trig.gpio;
  assign next_trig.gpio_adc = link_ok && i_trig.gpio;

  // oscillator measurement input; sampled, so only slow sources are meaningful
  wire osc_pick = (32'(i_osc_sel) < OSC_N) ? i_osc_clks[i_osc_sel] : 1'b0;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_gate <= '0;
      o_trig <= '0;
      o_hsi_feed <= '0;
      o_wide_timer_chan <= 1'b0;
    end else begin
      o_gate <= next_gate;
      o_trig <= next_trig;
      o_hsi_feed <= i_hsi_req & {HSI_N{!nm_off}};
      o_wide_timer_chan <= link_ok && osc_pick;
    end
  end

  // stop-mode wake interrupts of the serial and two-wire ports
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_serial_wake_irq <= 1'b0;
      o_two_wire_wake_irq <= 1'b0;
    end else begin
      o_serial_wake_irq <= is_stop(mode) && serial_wake;
      o_two_wire_wake_irq <= is_stop(mode) && tw_wake;
    end
  end

  // pull settings; load only while running, cleared on shutdown exit
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pull_cfg <= {IO_N{`PMW_PULL_FLOAT}};
      o_pull_hold <= 1'b0;
    end else begin
      if (leave_shutdown) begin
        o_pull_cfg <= {IO_N{`PMW_PULL_FLOAT}};
      end else if (i_pull_load && state == pmw_st_active) begin
        o_pull_cfg <= i_pull_cfg;
      end
      o_pull_hold <= nm_off;
    end
  end

  // i/o analog state; a wake from standby or shutdown is a reset too
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_io_analog <= `PMW_IO_ANALOG_RST;
      o_reset_pullup_en <= `PMW_RST_PULLUP_RST;
      o_on_backup <= 1'b0;
    end else begin
      o_io_analog <= leave_off ? 1'b1 : (i_io_release ? 1'b0 : o_io_analog);
      o_reset_pullup_en <= !i_internal_reset;
      o_on_backup <= !i_main_supply_ok;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_sleep_wake;
    (state == pmw_st_low) && is_sleep(mode) && wake_qual;
  endsequence

  sequence s_core_back;
    ##[1:WAKE_MAX] o_gate.core_run;
  endsequence

  resume_latency_a: assert property (s_sleep_wake |-> s_core_back)
    else $error("core not resumed within limit after sleep wake");
  sleep_core_halt_a: assert property (is_sleep(o_mode) && state == pmw_st_low |-> !o_gate.core_run)
    else $error("core running in sleep");
  lp_no_pll_a: assert property (is_lp(o_mode) |-> !o_gate.pll_allowed && !o_gate.rng_en
                                && o_gate.low_power_regulator && !o_gate.radio_en)
    else $error("low-power mode gating wrong");
  stop_flash_off_a: assert property (is_stop(o_mode) |-> !o_gate.flash_on && o_gate.sram_on
                                     && !o_gate.other_periph_en)
    else $error("stop mode memory gating wrong");
  stop_exit_a: assert property ((state == pmw_st_low) && is_stop(mode) && wake_qual
                                |=> state == pmw_st_resume)
    else $error("stop wake not taken");
  hse_follow_a: assert property (is_stop(o_mode) |-> o_gate.hse_on == $past(i_radio_needs_hse))
    else $error("fast oscillator not following radio");
  hsi_feed_a: assert property ((o_hsi_feed & ~$past(i_hsi_req)) == '0)
    else $error("16m oscillator fed to a non-requester");
  serial_wake_a: assert property (is_stop(mode) && i_wake.serial_frame |=> o_serial_wake_irq)
    else $error("serial frame wake missing");
  shutdown_clear_a: assert property (leave_shutdown |=> o_pull_cfg == '0)
    else $error("pull settings kept after shutdown");
  backup_hold_a: assert property (!i_main_supply_ok && state == pmw_st_low |=> state == pmw_st_low)
    else $error("woke while on backup supply");
  stop_links_a: assert property (is_stop(o_mode) |-> !o_trig.tim_sync && !o_trig.tim_adc
                                 && !o_trig.tim_dma && !o_trig.break_in && !o_trig.adc_wdg_tim)
    else $error("timer link active in stop");
  flash_pd_a: assert property ($rose(flash_pd) |-> !$past(i_radio_in_use) && $past(i_code_in_sram))
    else $error("flash powered down while radio or flash code active");

endmodule

/* verif/pmw_core_model.sv */
// application core model: picks the target mode, then raises the sleep request
`timescale 1ns/1ps
module pmw_core_model
  import pmw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_go,
  input wire pmw_mode_t i_mode,
  output pmw_mode_t o_target_mode,
  output logic o_sleep_req
);
  // quiet core at time zero; one process owns each variable
  logic armed = 1'b0;
  logic req = 1'b0;
  pmw_mode_t tgt = PMW_RUN;

  assign o_sleep_req = req;
  assign o_target_mode = tgt;

  // mode settles a cycle ahead of the request so it is never sampled mid-change
  always @(negedge i_clk) begin
    req <= armed;
    armed <= i_go;
    if (i_go) begin
      tgt <= i_mode;
    end
  end
endmodule

/* verif/test_pmw_ctrl.sv */
// self-checking bench for the power-mode and wakeup controller
`timescale 1ns/1ps
module test_pmw_ctrl;
  import pmw_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic go = 1'b0;
  pmw_mode_t go_mode = PMW_RUN;
  pmw_mode_t i_target_mode, o_mode, m;
  logic i_sleep_req;
  logic i_lp_run = 1'b0, i_irq_event = 1'b0, i_main_supply_ok = 1'b1, i_internal_reset = 1'b0;
  logic i_io_release = 1'b0, i_pull_load = 1'b0, i_radio_needs_hse = 1'b0, i_hse_enable = 1'b0;
  logic i_hsi_enable = 1'b0, i_flash_pd_req = 1'b0, i_flash_pd_clr = 1'b0, i_radio_in_use = 1'b1;
  logic i_code_in_sram = 1'b1, i_ram_a_gate = 1'b0, i_ram_b_gate = 1'b0;
  pmw_wake_t i_wake = '0;
  pmw_trig_in_t i_trig = '0;
  logic [31:0] i_pull_cfg = '0, pc, lfsr = 32'h0001_09fe;
  logic [3:0] i_hsi_req = '0;
  logic [5:0] i_osc_clks = '0;
  logic [2:0] i_osc_sel = '0;
  pmw_gate_t o_gate;
  pmw_trig_out_t o_trig;
  logic [3:0] o_hsi_feed;
  logic [31:0] o_pull_cfg;
  logic o_serial_wake_irq, o_two_wire_wake_irq, o_pull_hold, o_io_analog, o_reset_pullup_en;
  logic o_on_backup, o_flash_pd, o_wide_timer_chan;
  int mismatches = 0;
  int tests_run = 0;

  always #2 i_clk = ~i_clk;

  pmw_core_model pmw_core_model_i (.i_clk(i_clk), .i_go(go), .i_mode(go_mode),
    .o_target_mode(i_target_mode), .o_sleep_req(i_sleep_req));

  pmw_ctrl pmw_ctrl_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_target_mode(i_target_mode),
    .i_sleep_req(i_sleep_req), .i_lp_run(i_lp_run), .i_irq_event(i_irq_event), .i_wake(i_wake),
    .i_main_supply_ok(i_main_supply_ok), .i_internal_reset(i_internal_reset),
    .i_io_release(i_io_release), .i_pull_load(i_pull_load), .i_pull_cfg(i_pull_cfg),
    .i_radio_needs_hse(i_radio_needs_hse), .i_hse_enable(i_hse_enable), .i_hsi_enable(i_hsi_enable),
    .i_hsi_req(i_hsi_req), .i_flash_pd_req(i_flash_pd_req), .i_flash_pd_clr(i_flash_pd_clr),
    .i_radio_in_use(i_radio_in_use), .i_code_in_sram(i_code_in_sram), .i_ram_a_gate(i_ram_a_gate),
    .i_ram_b_gate(i_ram_b_gate), .i_trig(i_trig), .i_osc_clks(i_osc_clks), .i_osc_sel(i_osc_sel),
    .o_mode(o_mode), .o_gate(o_gate), .o_trig(o_trig), .o_hsi_feed(o_hsi_feed),
    .o_serial_wake_irq(o_serial_wake_irq), .o_two_wire_wake_irq(o_two_wire_wake_irq),
    .o_pull_cfg(o_pull_cfg), .o_pull_hold(o_pull_hold), .o_io_analog(o_io_analog),
    .o_reset_pullup_en(o_reset_pullup_en), .o_on_backup(o_on_backup), .o_flash_pd(o_flash_pd),
    .o_wide_timer_chan(o_wide_timer_chan));

  // pseudo-random source, fixed start so every run repeats
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic stop_m();
    return m == PMW_STOP0 || m == PMW_STOP1;
  endfunction

  // reference gating of the interconnect for the modelled mode
  function automatic pmw_trig_out_t trig_exp(input pmw_trig_in_t t);
    logic on;
    on = !stop_m();
    return {t.tim_sync & on, t.tim_adc & on, t.tim_dma & on, t.adc_watchdog & on,
      on & (t.brk_clk_fail | t.brk_hard_fault | t.brk_ram_parity | t.brk_flash_ecc | t.brk_volt_det),
      t.cal_alarm | t.cal_tamper | t.gpio, t.gpio & on, t.gpio & on};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic pulse(ref logic s);
    @(negedge i_clk);
    s = 1'b1;
    @(negedge i_clk);
    s = 1'b0;
  endtask

  // random traffic on the pass-through paths, compared one cycle later
  task automatic soak(input int n);
    logic [31:0] r;
    pmw_trig_in_t pt;
    logic [3:0] ph;
    logic pw, pr;
    for (int k = 0; k <= n; k++) begin
      @(negedge i_clk);
      if (k > 0) begin
        chk(o_trig, trig_exp(pt), "trig");
        chk(o_hsi_feed, ph, "hsi feed");
        chk(o_wide_timer_chan, pw & !stop_m(), "wide timer");
        chk(o_reset_pullup_en, !pr, "reset pullup");
      end
      r = rnd();
      {i_trig, i_hsi_req, i_osc_clks, i_internal_reset} = r[22:0];
      i_osc_sel = r[25] ? {2'h2, r[23]} : {1'b0, r[24:23]};
      pt = i_trig;
      ph = i_hsi_req;
      pr = i_internal_reset;
      pw = i_osc_clks[i_osc_sel];
    end
  endtask

  task automatic gate_chk();
    logic lp;
    logic off;
    lp = m == PMW_LOW_POWER_RUN || m == PMW_LOW_POWER_SLEEP;
    off = m == PMW_STANDBY || m == PMW_SHUTDOWN;
    chk(o_gate.core_run, m == PMW_RUN || m == PMW_LOW_POWER_RUN, "core run");
    // both regulators are off once the core domain is unpowered
    chk({o_gate.main_regulator, o_gate.low_power_regulator},
      off ? 2'h0 : ((lp || m == PMW_STOP1) ? 2'h1 : 2'h2), "reg");
    chk({o_gate.wide_timer_en, o_gate.pll_allowed},
      {!stop_m() && !off, m == PMW_RUN || m == PMW_SLEEP}, "timer pll");
    if (lp) begin
      chk({o_gate.pll_allowed, o_gate.radio_en, o_gate.rng_en}, 3'h0, "lp clocks");
    end
    if (stop_m()) begin
      chk({o_gate.flash_on, o_gate.sram_on, o_gate.stop_periph_en, o_gate.other_periph_en}, 4'h6, "stop");
    end
    if (m == PMW_SLEEP || m == PMW_LOW_POWER_SLEEP) begin
      chk({o_gate.ram_bank_a_clk, o_gate.ram_bank_b_clk}, {!i_ram_a_gate, !i_ram_b_gate}, "ram clk");
    end
  endtask

  task automatic enter(input pmw_mode_t t);
    @(negedge i_clk);
    go_mode <= t;
    go <= 1'b1;
    @(negedge i_clk);
    go <= 1'b0;
    repeat (2) @(negedge i_clk);
    m = t;
    chk(o_mode, t, "mode");
    gate_chk();
  endtask

  // one-cycle wake pulse; the core must restart on the eighth edge
  task automatic wake(input logic [13:0] w, input logic irq);
    int n;
    @(negedge i_clk);
    i_wake = w;
    i_irq_event = irq;
    @(negedge i_clk);
    i_wake = '0;
    i_irq_event = 1'b0;
    chk(o_serial_wake_irq, stop_m() & |w[5:3], "serial irq");
    chk(o_two_wire_wake_irq, stop_m() & w[2], "two-wire irq");
    n = 0;
    while (o_gate.core_run !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(n, 8, "wake latency");
    m = i_lp_run ? PMW_LOW_POWER_RUN : PMW_RUN;
    @(negedge i_clk);
    chk(o_mode, m, "resumed mode");
  endtask

  task automatic no_wake(input logic [13:0] w, input logic irq);
    @(negedge i_clk);
    i_wake = w;
    i_irq_event = irq;
    repeat (12) begin
      @(negedge i_clk);
      chk(o_gate.core_run, 1'b0, "refused wake");
    end
    i_wake = '0;
    i_irq_event = 1'b0;
  endtask

  // hang guard, well beyond the expected run length
  initial begin
    #200000;
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    m = PMW_RUN;
    repeat (2) @(negedge i_clk);
    chk({o_io_analog, o_reset_pullup_en}, 2'h3, "in reset");
    repeat (2) @(negedge i_clk);
    i_rstn = 1'b1;
    @(negedge i_clk);
    chk({o_gate.core_run, o_io_analog}, 2'h3, "after reset");
    // legal pull codes only: the unused code folds to pull-down
    pc = rnd();
    for (int k = 0; k < 16; k++) begin
      if (pc[2*k +: 2] == 2'h3) begin
        pc[2*k +: 2] = 2'h2;
      end
    end
    i_pull_cfg = pc;
    pulse(i_pull_load);
    pulse(i_io_release);
    @(negedge i_clk);
    chk({o_pull_cfg, o_io_analog}, {pc, 1'b0}, "pulls loaded");
    // each sleep and stop mode, from run or low-power run
    for (int i = 0; i < 4; i++) begin
      @(negedge i_clk);
      i_lp_run = i[0];
      {i_ram_a_gate, i_ram_b_gate} = {i[0], !i[0]};
      repeat (2) @(negedge i_clk);
      m = i[0] ? PMW_LOW_POWER_RUN : PMW_RUN;
      chk(o_mode, m, "active mode");
      gate_chk();
      soak(10);
      enter(pmw_mode_t'(3'(i + 2)));
      soak(20);
      if (i > 1) begin
        // oscillators follow demand in stop without software enables
        i_hsi_req = 4'h2;
        i_radio_needs_hse = 1'b1;
        repeat (3) @(negedge i_clk);
        chk({o_gate.hse_on, o_gate.hsi_on}, 2'h3, "osc on demand");
        i_hsi_req = 4'h0;
        i_radio_needs_hse = 1'b0;
        repeat (3) @(negedge i_clk);
        chk({o_gate.hse_on, o_gate.hsi_on, o_hsi_feed}, 6'h0, "osc released");
      end
      wake(i > 1 ? 14'h1000 : 14'h0000, i < 2);
    end
    i_lp_run = 1'b0;
    // every stop wake source, alternating the two stop depths
    for (int j = 0; j < 12; j++) begin
      enter(j[0] ? PMW_STOP1 : PMW_STOP0);
      wake(14'h0004 << j, 1'b0);
    end
    // backup supply holds off wakes
    enter(PMW_STOP0);
    @(negedge i_clk);
    i_main_supply_ok = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(o_on_backup, 1'b1, "on backup");
    no_wake(14'h1100, 1'b1);
    i_main_supply_ok = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(o_on_backup, 1'b0, "supply back");
    wake(14'h1000, 1'b0);
    // standby keeps pulls, shutdown drops them
    enter(PMW_STANDBY);
    chk({o_pull_hold, o_pull_cfg}, {1'b1, pc}, "standby hold");
    no_wake(14'h3efc, 1'b1);
    wake(14'h0001, 1'b0);
    chk({o_pull_hold, o_pull_cfg, o_io_analog}, {1'b0, pc, 1'b1}, "standby exit");
    pulse(i_io_release);
    enter(PMW_SHUTDOWN);
    no_wake(14'h3efc, 1'b1);
    wake(14'h0100, 1'b0);
    chk({o_pull_cfg, o_io_analog}, {32'h0, 1'b1}, "shutdown exit");
    enter(PMW_SHUTDOWN);
    wake(14'h0002, 1'b0);
    // flash power-down only with radio idle and code in ram
    pulse(i_flash_pd_req);
    @(negedge i_clk);
    chk(o_flash_pd, 1'b0, "pd refused");
    i_radio_in_use = 1'b0;
    pulse(i_flash_pd_req);
    repeat (2) @(negedge i_clk);
    chk({o_flash_pd, o_gate.flash_on}, 2'h2, "pd taken");
    enter(PMW_SLEEP);
    wake(14'h0000, 1'b1);
    chk({o_flash_pd, o_gate.flash_on}, 2'h2, "pd kept");
    pulse(i_flash_pd_clr);
    repeat (2) @(negedge i_clk);
    chk({o_flash_pd, o_gate.flash_on}, 2'h1, "pd cleared");
    end_sim();
  end
endmodule
